/* pal_board.sv */
`timescale 1ns/100ps
`default_nettype none
module pal_board (
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  input  wire logic [4:0] pull,
  output var  logic [4:0] pin
);
  // released pin rests at its strap pull, never floats
  always_comb pin = (pin_oe & pin_out) | (~pin_oe & pull);
endmodule // pal_board
`default_nettype wire

/* pal_map.svh */
`ifndef PAL_MAP_SVH
`define PAL_MAP_SVH

// number of multiplexed strap/led pins
`define PAL_NUM_PINS 5
// pin indices, equal to the address bit each one sets
`define PAL_PIN_ACTIVITY 0
`define PAL_PIN_COLLISION 1
`define PAL_PIN_LINK 2
`define PAL_PIN_TX 3
`define PAL_PIN_RX 4
// unused: the captured address is not reset, hardware reset keeps it
`define PAL_ADDR_RESET 5'h00
// collision stretch time and clock rate
`define PAL_COL_STRETCH_MS 70
`define PAL_CLOCK_HZ 50000000
// divide first: the plain product does not fit a 32-bit integer
`define PAL_COL_STRETCH_CYCLES (`PAL_COL_STRETCH_MS * (`PAL_CLOCK_HZ / 1000))

`endif

/* pal_pkg.sv */
package pal_pkg;
  typedef enum logic [0:0] {
    PAL_SAMPLE = 1'b0,
    PAL_DRIVE  = 1'b1
  } pal_mode_t;
endpackage

/* pal_strap_led.sv */
// Operation
// - pins are inputs in reset, captured at release
// - after capture pins drive status indicators
// - software reset keeps strap and outputs
// - asserted output is inverse of captured strap
// - activity strap sets address bit 0
// - activity pin shows tx or rx activity
// - collision strap bit 1, stretched 70 ms
// - link strap bit 2, shows valid link
`timescale 1ns/100ps
`default_nettype none
`include "pal_map.svh"

// ==========================================
// multiplexed address strap and status pins
module pal_strap_led #(
  parameter int unsigned COL_STRETCH_CYCLES = `PAL_COL_STRETCH_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       hardware_reset_low_pin,
  input  wire logic       soft_reset,
  input  wire logic       tx_activity,
  input  wire logic       rx_activity,
  input  wire logic       collision,
  input  wire logic       link_valid,
  input  wire logic [4:0] strap_pin_in,
  output var  logic [4:0] strap_pin_out,
  output var  logic [4:0] strap_pin_oe,
  output var  logic [4:0] phy_address
);

  // ==========================================
  // pin roles, bit i of the pins is address bit i
  localparam int unsigned NUM_PINS = `PAL_NUM_PINS;
  localparam int unsigned PIN_ACT  = `PAL_PIN_ACTIVITY;
  localparam int unsigned PIN_COL  = `PAL_PIN_COLLISION;
  localparam int unsigned PIN_LINK = `PAL_PIN_LINK;
  localparam int unsigned PIN_TX   = `PAL_PIN_TX;
  localparam int unsigned PIN_RX   = `PAL_PIN_RX;

  // ==========================================
  // state
  typedef struct packed {
    pal_pkg::pal_mode_t mode;
    logic [4:0]         sync1;
    logic [4:0]         sync2;
    logic [4:0]         addr;
    logic [4:0]         pin_out;
  } pal_state_t;

  pal_state_t state;
  pal_state_t next_state;

  // ==========================================
  // internal signals
  logic [4:0] indicate;
  logic [4:0] drive_value;
  logic [4:0] drive_enable;
  logic       driving;
  logic       any_activity;
  logic       col_trigger;
  logic       col_active;
  logic       unused_soft_reset;

  // ==========================================
  // mode decode
  assign driving = (state.mode == pal_pkg::PAL_DRIVE);

  // ==========================================
  // collision stretch
  // collisions seen before the pins turn around cannot light anything
  assign col_trigger = collision & driving;

  pal_stretch #(
    .STRETCH_CYCLES(COL_STRETCH_CYCLES)
  ) u_col_stretch (
    .clock  (clock),
    .hardware_reset_low_pin (hardware_reset_low_pin),
    .trigger(col_trigger),
    .active (col_active)
  );

  // ==========================================
  // activity sources
  assign any_activity = tx_activity | rx_activity;

  // ==========================================
  // indication source and drive level per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    if (i == PIN_ACT) begin : g_act
      assign indicate[i] = any_activity;
    end else if (i == PIN_COL) begin : g_col
      assign indicate[i] = col_active;
    end else if (i == PIN_LINK) begin : g_link
      assign indicate[i] = link_valid;
    end else if (i == PIN_TX) begin : g_tx
      assign indicate[i] = tx_activity;
    end else begin : g_rx
      assign indicate[i] = rx_activity;
    end

    // led returns through its strap resistor, so lit is the inverse level
    assign drive_value[i]  = state.addr[i] ^ indicate[i];
    assign drive_enable[i] = driving;
  end

  // ==========================================
  // next state
  always_comb begin
    next_state       = state;
    // synchroniser runs through reset so the strap is settled at release
    next_state.sync1 = strap_pin_in;
    next_state.sync2 = state.sync1;
    if (!hardware_reset_low_pin) begin
      next_state.mode    = pal_pkg::PAL_SAMPLE;
      next_state.pin_out = 5'h00;
      // address kept; only the release edge recaptures it
    end else begin
      unique case (state.mode)
        pal_pkg::PAL_SAMPLE: begin
          // sync2 holds the pulled level seen while the pins were released
          next_state.addr    = state.sync2;
          next_state.mode    = pal_pkg::PAL_DRIVE;
          next_state.pin_out = state.sync2;
        end
        pal_pkg::PAL_DRIVE: begin
          // soft_reset deliberately ignored: strap and pins untouched
          next_state.pin_out = drive_value;
        end
      endcase
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clock) begin
    state <= next_state;
  end

  // ==========================================
  // outputs
  // pins only float as inputs while sampling; board pull sets level
  assign strap_pin_oe  = drive_enable;
  assign strap_pin_out = state.pin_out;
  assign phy_address   = state.addr;

  // ==========================================
  // software reset
  // neither recaptures the strap nor releases the pins
  assign unused_soft_reset = soft_reset;
endmodule // pal_strap_led
`default_nettype wire

/* pal_strap_led_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pal_strap_led_asserts #(parameter int unsigned COL_STRETCH_CYCLES = 20) (
  input wire logic clock, hardware_reset_low_pin, soft_reset, tx_activity, rx_activity, collision, link_valid,
  input wire logic [4:0] strap_pin_in, strap_pin_out, strap_pin_oe, phy_address
);
  default clocking @(posedge clock); endclocking
  default disable iff (!hardware_reset_low_pin);
  property p_rel; !$past(hardware_reset_low_pin) |-> strap_pin_oe == 5'h00; endproperty
  a_rel: assert property (p_rel) else $error("oe in reset");
  property p_drv; $past(hardware_reset_low_pin) |-> strap_pin_oe == 5'h1f; endproperty
  a_drv: assert property (p_drv) else $error("oe after");
  property p_sft; $past(hardware_reset_low_pin) && soft_reset |=> strap_pin_oe == 5'h1f && $stable(phy_address);
  endproperty
  a_sft: assert property (p_sft) else $error("soft reset");
  property p_cap; $rose(hardware_reset_low_pin) |=> phy_address == $past(strap_pin_in, 2); endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_hld; $past(hardware_reset_low_pin, 2) |-> $stable(phy_address); endproperty
  a_hld: assert property (p_hld) else $error("addr hold");
  property p_act; $past(strap_pin_oe[0]) |->
    strap_pin_out[0] == (phy_address[0] ^ $past(tx_activity | rx_activity)); endproperty
  a_act: assert property (p_act) else $error("activity");
  property p_lnk; $past(strap_pin_oe[2]) |->
    strap_pin_out[2] == (phy_address[2] ^ $past(link_valid)); endproperty
  a_lnk: assert property (p_lnk) else $error("link");
  // stretch counter then the pin register: two edges from collision to pin
  property p_col; collision && strap_pin_oe[1] |->
    ##2 strap_pin_out[1] != phy_address[1]; endproperty
  a_col: assert property (p_col) else $error("collision");
endmodule // pal_strap_led_asserts
`default_nettype wire

/* pal_stretch.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// pulse stretcher for the collision indication
module pal_stretch #(
  parameter int unsigned STRETCH_CYCLES = 3500000
) (
  input  wire logic clock,
  input  wire logic hardware_reset_low_pin,
  input  wire logic trigger,
  output var  logic active
);
  typedef struct packed {
    logic [22:0] count;
  } pal_stretch_state_t;

  pal_stretch_state_t state;
  pal_stretch_state_t next_state;

  always_comb begin
    next_state = state;
    if (trigger) begin
      // a new collision restarts the full period
      next_state.count = 23'(STRETCH_CYCLES);
    end else if (state.count != 23'h000000) begin
      next_state.count = state.count - 23'h000001;
    end
  end

  always_ff @(posedge clock) begin
    if (!hardware_reset_low_pin) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active = (state.count != 23'h000000);
endmodule // pal_stretch
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
bind pal_strap_led pal_strap_led_asserts #(.COL_STRETCH_CYCLES(COL_STRETCH_CYCLES)) u_chk (
  .clock, .hardware_reset_low_pin, .soft_reset, .tx_activity, .rx_activity, .collision, .link_valid,
  .strap_pin_in, .strap_pin_out, .strap_pin_oe, .phy_address);
module tb;
  localparam int N = 20;
  logic clock = 0, hardware_reset_low_pin = 0, soft_reset = 0, tx = 0, rx = 0, col = 0, lnk = 0;
  logic [4:0] pull = 0, pin, pout, poe, addr, ind = 0, xa = 0, e;
  logic rq = 0, lit = 0;
  int err_count = 0, samples_checked = 0, cyc = 0, left = 0, run = 0;
  pal_strap_led #(.COL_STRETCH_CYCLES(N)) u_pal_strap_led (.clock, .hardware_reset_low_pin, .soft_reset,
    .tx_activity(tx), .rx_activity(rx), .collision(col), .link_valid(lnk), .strap_pin_in(pin),
    .strap_pin_out(pout), .strap_pin_oe(poe), .phy_address(addr));
  pal_board u_pal_board (.pin_out(pout), .pin_oe(poe), .pull(pull), .pin(pin));
  initial forever #10 clock = ~clock;
  task automatic chk(input logic [4:0] a, input logic [4:0] x);
    samples_checked++;
    if (a !== x) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, x);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d checks=%0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // model sees the inputs as the design samples them, before this edge's drives land
  always @(posedge clock) begin
    ind <= {rx, tx, lnk, 1'b0, tx | rx};
    // stretch restarts on each collision once the pins drive
    left <= !hardware_reset_low_pin ? 0 : (col && run > 0) ? N : (left > 0 ? left - 1 : 0);
    lit <= left > 0;
    rq <= hardware_reset_low_pin;
    if (hardware_reset_low_pin && !rq) xa <= pull;
    run <= hardware_reset_low_pin ? run + 1 : 0;
    cyc <= cyc + 1;
    if (cyc > 2000) begin
      err_count++;
      report_and_stop();
    end
  end
  always @(negedge clock) begin
    chk(poe, rq ? 5'h1f : 5'h00);
    if (run >= 1) begin
      chk(addr, xa);
      e = xa ^ (run == 1 ? 5'h00 : (ind | {3'b000, lit, 1'b0}));
      chk(pout, e);
    end
  end
  initial begin
    void'($urandom(10588));
    repeat (3) begin
      @(posedge clock);
      hardware_reset_low_pin <= 0;
      col <= 0;
      pull <= 5'($urandom);
      repeat (3) @(posedge clock);
      hardware_reset_low_pin <= 1;
      repeat (200) begin
        @(posedge clock);
        {soft_reset, tx, rx, lnk} <= 4'($urandom);
        col <= 5'($urandom) == 5'h00;
      end
    end
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
